// ### logic/motion_pkg.sv
// Shared constants, register map and carrier types for the motion input dispatcher
package motion_pkg;

	// Register byte offsets
	localparam logic [11:0] REG_CONFIG     = 12'h000;
	localparam logic [11:0] REG_PRESET     = 12'h004;
	localparam logic [11:0] REG_STATUS     = 12'h008;
	localparam logic [11:0] REG_SPEED_BASE = 12'h400;

	// Configuration field positions
	localparam int CFG_LIMIT_LSB = 0;
	localparam int CFG_HMODE_LSB = 4;
	localparam int CFG_SLIT_BIT  = 6;
	localparam int CFG_MONA_LSB  = 8;
	localparam int CFG_MONB_LSB  = 16;

	// Status field positions
	localparam int ST_ERR_BIT   = 0;
	localparam int ST_HSET_BIT  = 1;
	localparam int ST_HDONE_BIT = 2;
	localparam int ST_PRST_BIT  = 3;
	localparam int ST_ELEC_BIT  = 4;

	// Limit sensor action codes (3-bit two's complement)
	localparam logic [2:0] LIM_HOME_ONLY   = 3'h7;
	localparam logic [2:0] LIM_IMM         = 3'h0;
	localparam logic [2:0] LIM_DECEL       = 3'h1;
	localparam logic [2:0] LIM_IMM_ALARM   = 3'h2;
	localparam logic [2:0] LIM_DECEL_ALARM = 3'h3;

	// Home-seeking methods
	localparam logic [1:0] HM_TWO_SENSOR   = 2'h0;
	localparam logic [1:0] HM_THREE_SENSOR = 2'h1;
	localparam logic [1:0] HM_ONE_WAY      = 2'h2;

	// Values after reset
	localparam logic [2:0]  RST_LIMIT_ACT = LIM_IMM_ALARM;
	localparam logic [1:0]  RST_HMODE     = HM_THREE_SENSOR;
	localparam logic [7:0]  RST_MON_A     = 8'h01;
	localparam logic [7:0]  RST_MON_B     = 8'h08;
	localparam logic [31:0] RST_PRESET    = 32'h0000_0000;

	localparam int DIN_W    = 21;
	localparam int SPEED_N  = 256;

	// Discrete command and sensor inputs
	typedef struct packed {
		logic fast_homing_req;
		logic homing_req;
		logic jog_fwd;
		logic jog_rev;
		logic fast_jog_fwd;
		logic fast_jog_rev;
		logic inch_fwd;
		logic inch_rev;
		logic combined_jog_fwd;
		logic combined_jog_rev;
		logic run_fwd;
		logic run_rev;
		logic limit_fwd;
		logic limit_rev;
		logic mech_origin_sensor;
		logic slit;
		logic preset_req;
		logic electrical_origin_hold;
		logic monitor_select_a;
		logic monitor_select_b;
		logic torque_limited_flag;
	} din_t;

	typedef enum logic [3:0] {
		CMD_NONE, CMD_STOP_IMM, CMD_STOP_DECEL, CMD_JOG, CMD_FAST_JOG, CMD_INCH,
		CMD_COMBINED_JOG, CMD_RUN, CMD_HOME_SEEK, CMD_FAST_HOME
	} cmd_kind_t;

	// Command to the profile generator, valid for one cycle
	typedef struct packed {
		logic        valid;
		cmd_kind_t   kind;
		logic        rev;
		logic [31:0] speed;
	} motion_cmd_t;

endpackage : motion_pkg

// ### logic/input_sync.sv
// Two-stage synchroniser with edge detection for the discrete inputs
`timescale 1ns/100ps
`default_nettype none
module input_sync
	import motion_pkg::*;
#(
	parameter int W = DIN_W
) (
	// Clock and reset
	input  wire logic         i_clk,
	input  wire logic         i_nrst,
	// Raw and conditioned inputs
	input  wire logic [W-1:0] i_d,
	output logic      [W-1:0] o_lvl,
	output logic      [W-1:0] o_rise,
	output logic      [W-1:0] o_fall
);
	logic [W-1:0] meta;
	logic [W-1:0] prev;

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			meta  <= '0;
			o_lvl <= '0;
			prev  <= '0;
		end else begin
			meta  <= i_d;
			o_lvl <= meta;
			prev  <= o_lvl;
		end
	end

	assign o_rise = o_lvl & ~prev;
	assign o_fall = ~o_lvl & prev;

endmodule : input_sync
`default_nettype wire

// ### logic/monitor_select.sv
// Monitor content selection for the two monitor request inputs
`timescale 1ns/100ps
`default_nettype none
module monitor_select
	import motion_pkg::*;
(
	// Selection
	input  wire logic [7:0]  i_code_a,
	input  wire logic [7:0]  i_code_b,
	input  wire logic        i_req_a,
	input  wire logic        i_req_b,
	// Sources
	input  wire logic [31:0] i_fb,
	input  wire logic [31:0] i_fb32,
	input  wire logic [31:0] i_cmd,
	input  wire logic [31:0] i_cmd32,
	input  wire logic [7:0]  i_alarm,
	// Result
	output logic [39:0]      o_data,
	output logic             o_valid
);
	function automatic logic [40:0] pick(input logic [7:0] code, input logic [31:0] fb,
		input logic [31:0] fb32, input logic [31:0] cmd, input logic [31:0] cmd32,
		input logic [7:0] alarm);
		logic [31:0] pos;
		pos = 32'h0000_0000;
		case (code)
			8'h01, 8'h09: pos = fb;
			8'h02, 8'h0a: pos = fb32;
			8'h03, 8'h0b: pos = cmd;
			8'h04, 8'h0c: pos = cmd32;
			default: pos = 32'h0000_0000;
		endcase
		if (code >= 8'h01 && code <= 8'h04)
			pick = {1'b1, 8'h00, pos};
		else if (code == 8'h08)
			pick = {1'b1, 32'h0000_0000, alarm};
		else if (code >= 8'h09 && code <= 8'h0c)
			pick = {1'b1, alarm, pos};
		else
			pick = {1'b0, 40'h00_0000_0000};
	endfunction : pick

	logic [40:0] sel_a;
	logic [40:0] sel_b;

	assign sel_a   = pick(i_code_a, i_fb, i_fb32, i_cmd, i_cmd32, i_alarm);
	assign sel_b   = pick(i_code_b, i_fb, i_fb32, i_cmd, i_cmd32, i_alarm);
	// Request A wins when both are held
	assign o_data  = i_req_a ? sel_a[39:0] : (i_req_b ? sel_b[39:0] : 40'h00_0000_0000);
	assign o_valid = i_req_a ? sel_a[40] : (i_req_b ? sel_b[40] : 1'b0);

endmodule : monitor_select
`default_nettype wire

// ### logic/motion_input_command_dispatch.sv
// Input dispatcher turning host input levels and edges into motion commands
//
// Notes on behaviour
// - Fast-homing request rising starts a high-speed return to the stored home.
// - Fast-homing with no home set raises a sticky error and issues no motion.
// - Homing request runs a home search; homing-done rises once motion ends.
// - Normal jog runs while a jog input is held, stopping on release.
// - Fast-jog input rising issues a high-speed jog in that direction.
// - Inching input rising issues a single small step in that direction.
// - Combined-jog input rising issues a combined jog in that direction.
// - Run input rising starts continuous motion at the selected entry's speed.
// - Same-direction run reasserted while decelerating re-accelerates the motion.
// - Both run inputs held together decelerate the motor to a stop.
// - Changing the data number during a run switches to the new speed.
// - During homing, a limit sensor steers the search per the home method.
// - Outside homing a limit stops per action code -1..3, default 2.
// - Home method 0 two-sensor, 1 three-sensor default, 2 one-way rotation.
// - With slit enabled, methods 1 and 2 find home only while the slit input is active.
// - Preset loads command and feedback counters and writes nonvolatile storage.
// - Preset is refused during motion or while torque limiting is active.
// - Preset-in-progress stands through the preset; homing-done rises at its end.
// - Electrical-home hold references positions to the point captured at its rise.
// - Rebasing during motion leaves the running command's target untouched.
// - Fast homing is inhibited while the electrical-home hold is active.
// - Each monitor request picks content from its own code, defaults 1 and 8.
//
// Register access over Wishbone and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module motion_input_command_dispatch
	import motion_pkg::*;
(
	// Clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_nrst,
	// Wishbone slave
	input  wire logic        i_wb_cyc,
	input  wire logic        i_wb_stb,
	input  wire logic        i_wb_we,
	input  wire logic [11:0] i_wb_adr,
	input  wire logic [3:0]  i_wb_sel,
	input  wire logic [31:0] i_wb_dat,
	output logic      [31:0] o_wb_dat,
	output logic             o_wb_ack,
	// Host inputs
	input  wire din_t        i_din,
	input  wire logic [7:0]  i_data_sel,
	// Profile generator and counters
	input  wire logic        i_motion_busy,
	input  wire logic        i_motion_done,
	input  wire logic        i_decelerating,
	input  wire logic        i_nv_done,
	input  wire logic        i_home_invalidate,
	input  wire logic [31:0] i_fb_pos,
	input  wire logic [31:0] i_cmd_pos,
	input  wire logic [31:0] i_fb_cnt32,
	input  wire logic [31:0] i_cmd_cnt32,
	input  wire logic [7:0]  i_alarm_code,
	// Commands and status
	output motion_cmd_t      o_cmd,
	output logic             o_homing_done,
	output logic             o_preset_in_progress,
	output logic             o_pos_load,
	output logic             o_nv_write,
	output logic      [31:0] o_pos_load_value,
	output logic             o_elec_active,
	output logic      [31:0] o_elec_offset,
	output logic             o_limit_alarm,
	output logic             o_fast_home_err,
	output logic      [39:0] o_mon_data,
	output logic             o_mon_valid
);
	typedef enum logic [2:0] {
		ST_IDLE, ST_MOVE, ST_HOME, ST_HOME_STOP, ST_FAST_HOME, ST_PRESET
	} state_t;

	function automatic logic [31:0] apply_sel(input logic [31:0] old,
		input logic [31:0] wdat, input logic [3:0] sel);
		for (int i = 0; i < 4; i++)
			apply_sel[8*i +: 8] = sel[i] ? wdat[8*i +: 8] : old[8*i +: 8];
	endfunction : apply_sel

	state_t      state;
	state_t      next_state;
	din_t        lvl;
	din_t        rise;
	din_t        fall;
	logic [31:0] cfg;
	logic [31:0] preset_val;
	logic [31:0] speed_tab [SPEED_N];
	logic        home_set;
	logic        home_rev;
	logic        run_active;
	logic        run_rev_dir;
	logic [7:0]  prev_sel;
	logic        next_issue;
	cmd_kind_t   next_kind;
	logic        next_rev;
	logic        next_err;
	logic        next_alarm;
	logic        next_load;
	logic        home_found;
	logic        wb_req;
	logic        wb_wr;
	logic [2:0]  lim_act;
	logic [1:0]  hmode;
	logic [31:0] fb_rel;
	logic [31:0] cmd_rel;
	logic [39:0] mon_d;
	logic        mon_v;

	input_sync #(.W(DIN_W)) u_sync (
		.i_clk  (i_clk),
		.i_nrst (i_nrst),
		.i_d    (i_din),
		.o_lvl  (lvl),
		.o_rise (rise),
		.o_fall (fall)
	);

	assign lim_act = cfg[CFG_LIMIT_LSB +: 3];
	assign hmode   = cfg[CFG_HMODE_LSB +: 2];
	assign wb_req  = i_wb_cyc && i_wb_stb && !o_wb_ack;
	assign wb_wr   = wb_req && i_wb_we;

	// Register file; settings only change at the acknowledging edge
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			cfg        <= {8'h00, RST_MON_B, RST_MON_A, 1'b0, 1'b0, RST_HMODE, 1'b0, RST_LIMIT_ACT};
			preset_val <= RST_PRESET;
		end else if (wb_wr) begin
			if (i_wb_adr == REG_CONFIG)
				cfg <= apply_sel(cfg, i_wb_dat, i_wb_sel);
			if (i_wb_adr == REG_PRESET)
				preset_val <= apply_sel(preset_val, i_wb_dat, i_wb_sel);
		end
	end

	// Speed table is memory and carries no reset
	always_ff @(posedge i_clk) begin
		if (wb_wr && i_wb_adr[11:10] == REG_SPEED_BASE[11:10])
			speed_tab[i_wb_adr[9:2]] <= apply_sel(speed_tab[i_wb_adr[9:2]], i_wb_dat, i_wb_sel);
	end

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_wb_ack <= 1'b0;
			o_wb_dat <= 32'h0000_0000;
		end else begin
			o_wb_ack <= wb_req;
			o_wb_dat <= 32'h0000_0000;
			if (wb_req && !i_wb_we) begin
				if (i_wb_adr == REG_CONFIG)
					o_wb_dat <= cfg;
				else if (i_wb_adr == REG_PRESET)
					o_wb_dat <= preset_val;
				else if (i_wb_adr == REG_STATUS)
					o_wb_dat <= {21'h00_0000, 3'(state), 3'h0, o_elec_active,
						o_preset_in_progress, o_homing_done, home_set, o_fast_home_err};
				else if (i_wb_adr[11:10] == REG_SPEED_BASE[11:10])
					o_wb_dat <= speed_tab[i_wb_adr[9:2]];
			end
		end
	end

	// Home detection per method; slit qualifies the origin-sensor methods 1 and 2
	always_comb begin
		home_found = 1'b0;
		case (hmode)
			HM_TWO_SENSOR: home_found = fall.limit_fwd || fall.limit_rev;
			HM_THREE_SENSOR, HM_ONE_WAY: home_found = lvl.mech_origin_sensor &&
				(!cfg[CFG_SLIT_BIT] || lvl.slit);
			default: home_found = 1'b0;
		endcase
	end

	// Dispatch: one command per cycle, limit and both-run stops ahead of starts
	always_comb begin
		next_state = state;
		next_issue = 1'b0;
		next_kind  = CMD_NONE;
		next_rev   = 1'b0;
		next_err   = 1'b0;
		next_alarm = 1'b0;
		next_load  = 1'b0;
		case (state)
			ST_IDLE, ST_MOVE: begin
				if (state == ST_MOVE && (rise.limit_fwd || rise.limit_rev) &&
					lim_act != LIM_HOME_ONLY) begin
					next_issue = 1'b1;
					next_kind  = (lim_act == LIM_IMM || lim_act == LIM_IMM_ALARM) ?
						CMD_STOP_IMM : CMD_STOP_DECEL;
					next_alarm = (lim_act == LIM_IMM_ALARM || lim_act == LIM_DECEL_ALARM);
				end else if (lvl.run_fwd && lvl.run_rev) begin
					if (run_active && !i_decelerating) begin
						next_issue = 1'b1;
						next_kind  = CMD_STOP_DECEL;
					end
				end else if (rise.run_fwd || rise.run_rev) begin
					next_issue = 1'b1;
					next_kind  = CMD_RUN;
					next_rev   = rise.run_rev;
					next_state = ST_MOVE;
				end else if (run_active && i_data_sel != prev_sel && !i_decelerating) begin
					next_issue = 1'b1;
					next_kind  = CMD_RUN;
					next_rev   = run_rev_dir;
				end else if (rise.jog_fwd || rise.jog_rev) begin
					next_issue = 1'b1;
					next_kind  = CMD_JOG;
					next_rev   = rise.jog_rev;
					next_state = ST_MOVE;
				end else if (state == ST_MOVE && (fall.jog_fwd || fall.jog_rev)) begin
					next_issue = 1'b1;
					next_kind  = CMD_STOP_DECEL;
				end else if (rise.fast_jog_fwd || rise.fast_jog_rev) begin
					next_issue = 1'b1;
					next_kind  = CMD_FAST_JOG;
					next_rev   = rise.fast_jog_rev;
					next_state = ST_MOVE;
				end else if (rise.inch_fwd || rise.inch_rev) begin
					next_issue = 1'b1;
					next_kind  = CMD_INCH;
					next_rev   = rise.inch_rev;
					next_state = ST_MOVE;
				end else if (rise.combined_jog_fwd || rise.combined_jog_rev) begin
					next_issue = 1'b1;
					next_kind  = CMD_COMBINED_JOG;
					next_rev   = rise.combined_jog_rev;
					next_state = ST_MOVE;
				end else if (state == ST_IDLE && rise.fast_homing_req) begin
					if (!home_set)
						next_err = 1'b1;
					else if (!lvl.electrical_origin_hold) begin
						next_issue = 1'b1;
						next_kind  = CMD_FAST_HOME;
						next_state = ST_FAST_HOME;
					end
				end else if (state == ST_IDLE && rise.homing_req) begin
					next_issue = 1'b1;
					next_kind  = CMD_HOME_SEEK;
					next_state = ST_HOME;
				end else if (state == ST_IDLE && rise.preset_req && !i_motion_busy &&
					!lvl.torque_limited_flag) begin
					next_load  = 1'b1;
					next_state = ST_PRESET;
				end else if (state == ST_MOVE && i_motion_done) begin
					next_state = ST_IDLE;
				end
			end
			ST_HOME: begin
				if (home_found) begin
					next_issue = 1'b1;
					next_kind  = CMD_STOP_IMM;
					next_state = ST_HOME_STOP;
				end else if ((rise.limit_fwd || rise.limit_rev) && hmode != HM_ONE_WAY) begin
					next_issue = 1'b1;
					next_kind  = CMD_HOME_SEEK;
					next_rev   = !home_rev;
				end
			end
			ST_HOME_STOP, ST_FAST_HOME: begin
				if (i_motion_done)
					next_state = ST_IDLE;
			end
			ST_PRESET: begin
				if (i_nv_done)
					next_state = ST_IDLE;
			end
			default: next_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst)
			state <= ST_IDLE;
		else
			state <= next_state;
	end

	// Command output and run tracking
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_cmd       <= '0;
			run_active  <= 1'b0;
			run_rev_dir <= 1'b0;
			home_rev    <= 1'b0;
			prev_sel    <= 8'h00;
		end else begin
			o_cmd.valid <= next_issue;
			o_cmd.kind  <= next_kind;
			o_cmd.rev   <= next_rev;
			o_cmd.speed <= speed_tab[i_data_sel];
			prev_sel    <= i_data_sel;
			if (next_issue && next_kind == CMD_RUN) begin
				run_active  <= 1'b1;
				run_rev_dir <= next_rev;
			end else if (next_issue || next_state == ST_IDLE)
				run_active <= 1'b0;
			if (next_issue && next_kind == CMD_HOME_SEEK)
				home_rev <= next_rev;
		end
	end

	// Home state, completion and preset side effects
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			home_set             <= 1'b0;
			o_homing_done        <= 1'b0;
			o_preset_in_progress <= 1'b0;
			o_pos_load           <= 1'b0;
			o_nv_write           <= 1'b0;
			o_pos_load_value     <= 32'h0000_0000;
		end else begin
			o_pos_load <= next_load;
			o_nv_write <= next_load;
			if (next_load)
				o_pos_load_value <= preset_val;
			o_preset_in_progress <= (next_state == ST_PRESET);
			if ((state == ST_HOME_STOP || state == ST_FAST_HOME) && i_motion_done ||
				state == ST_PRESET && i_nv_done)
				o_homing_done <= 1'b1;
			else if (next_issue && next_kind == CMD_HOME_SEEK && state == ST_IDLE ||
				next_load)
				o_homing_done <= 1'b0;
			if (state == ST_HOME_STOP && i_motion_done || state == ST_PRESET && i_nv_done)
				home_set <= 1'b1;
			else if (i_home_invalidate)
				home_set <= 1'b0;
		end
	end

	// Sticky error: a new event wins over a software clear in the same cycle
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_fast_home_err <= 1'b0;
			o_limit_alarm   <= 1'b0;
		end else begin
			o_limit_alarm <= next_alarm;
			if (next_err)
				o_fast_home_err <= 1'b1;
			else if (wb_wr && i_wb_adr == REG_STATUS && i_wb_sel[0] && i_wb_dat[ST_ERR_BIT])
				o_fast_home_err <= 1'b0;
		end
	end

	// Electrical home; the running command is never re-sent, so its target stays put
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_elec_active <= 1'b0;
			o_elec_offset <= 32'h0000_0000;
		end else begin
			o_elec_active <= lvl.electrical_origin_hold;
			if (rise.electrical_origin_hold)
				o_elec_offset <= i_fb_pos;
		end
	end

	assign fb_rel  = o_elec_active ? i_fb_pos - o_elec_offset : i_fb_pos;
	assign cmd_rel = o_elec_active ? i_cmd_pos - o_elec_offset : i_cmd_pos;

	monitor_select u_mon (
		.i_code_a (cfg[CFG_MONA_LSB +: 8]),
		.i_code_b (cfg[CFG_MONB_LSB +: 8]),
		.i_req_a  (lvl.monitor_select_a),
		.i_req_b  (lvl.monitor_select_b),
		.i_fb     (fb_rel),
		.i_fb32   (i_fb_cnt32),
		.i_cmd    (cmd_rel),
		.i_cmd32  (i_cmd_cnt32),
		.i_alarm  (i_alarm_code),
		.o_data   (mon_d),
		.o_valid  (mon_v)
	);

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_mon_data  <= 40'h00_0000_0000;
			o_mon_valid <= 1'b0;
		end else begin
			o_mon_data  <= mon_d;
			o_mon_valid <= mon_v;
		end
	end

	chk_fast_home_err: assert property (@(posedge i_clk) disable iff (!i_nrst)
		state == ST_IDLE && rise.fast_homing_req && !home_set &&
		!(lvl.run_fwd && lvl.run_rev) && !next_issue |=>
		o_fast_home_err && !(o_cmd.valid && o_cmd.kind == CMD_FAST_HOME))
		else $error("fast homing without home did not flag error");
	chk_fast_home_inhibit: assert property (@(posedge i_clk) disable iff (!i_nrst)
		o_cmd.valid && o_cmd.kind == CMD_FAST_HOME |-> $past(home_set) &&
		$past(lvl.electrical_origin_hold) == 1'b0)
		else $error("fast homing issued while inhibited");
	chk_preset_refuse: assert property (@(posedge i_clk) disable iff (!i_nrst)
		o_pos_load |-> !$past(i_motion_busy) && !$past(lvl.torque_limited_flag))
		else $error("preset accepted during motion or torque limit");
	chk_preset_pair: assert property (@(posedge i_clk) disable iff (!i_nrst)
		o_pos_load |-> o_nv_write && o_pos_load_value == preset_val ##1
		o_preset_in_progress)
		else $error("preset load without nonvolatile write");
	chk_preset_done: assert property (@(posedge i_clk) disable iff (!i_nrst)
		state == ST_PRESET && i_nv_done |=> o_homing_done && !o_preset_in_progress)
		else $error("preset completion not reported");
	chk_limit_stop: assert property (@(posedge i_clk) disable iff (!i_nrst)
		state == ST_MOVE && rise.limit_fwd && lim_act == LIM_IMM_ALARM |=>
		o_cmd.valid && o_cmd.kind == CMD_STOP_IMM && o_limit_alarm)
		else $error("limit did not stop with alarm");
	chk_run_both_stop: assert property (@(posedge i_clk) disable iff (!i_nrst)
		(state == ST_IDLE || state == ST_MOVE) && lvl.run_fwd && lvl.run_rev && run_active &&
		!i_decelerating && !((rise.limit_fwd || rise.limit_rev) && state == ST_MOVE) |=>
		o_cmd.valid && o_cmd.kind == CMD_STOP_DECEL)
		else $error("both run inputs did not stop motor");
	chk_run_speed: assert property (@(posedge i_clk) disable iff (!i_nrst)
		o_cmd.valid && o_cmd.kind == CMD_RUN |-> o_cmd.speed == speed_tab[$past(i_data_sel)])
		else $error("run speed not from selected entry");
	chk_home_limit_turn: assert property (@(posedge i_clk) disable iff (!i_nrst)
		state == ST_HOME && !home_found && rise.limit_rev && hmode == HM_THREE_SENSOR |=>
		o_cmd.valid && o_cmd.kind == CMD_HOME_SEEK && o_cmd.rev != $past(home_rev))
		else $error("homing did not reverse at limit");
	chk_elec_capture: assert property (@(posedge i_clk) disable iff (!i_nrst)
		rise.electrical_origin_hold |=> o_elec_active && o_elec_offset == $past(i_fb_pos))
		else $error("electrical home not captured");

endmodule : motion_input_command_dispatch
`default_nettype wire

// ### tb/motion_far_end.sv
// Behavioural profile generator and position counter facing the dispatcher
`timescale 1ns/100ps
`default_nettype none
module motion_far_end
	import motion_pkg::*;
(
	// Clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_nrst,
	// From the dispatcher
	input  wire motion_cmd_t i_cmd,
	input  wire logic        i_nv_write,
	// To the dispatcher
	output logic             o_busy,
	output logic             o_done,
	output logic             o_decel,
	output logic             o_nv_done,
	output logic      [31:0] o_pos
);
	logic [3:0] left;
	logic [2:0] nv_left;
	logic       stop;

	assign stop = (i_cmd.kind == CMD_STOP_IMM) || (i_cmd.kind == CMD_STOP_DECEL);
	// The tail of every move counts as deceleration
	assign o_decel = o_busy && (left < 4'h4);

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			left <= 4'h0;
			o_busy <= 1'b0;
			o_done <= 1'b0;
		end else begin
			o_done <= (left == 4'h1);
			if (i_cmd.valid) begin
				left <= stop ? 4'h2 : 4'hc;
				o_busy <= 1'b1;
			end else if (left != 4'h0) begin
				left <= left - 4'h1;
				o_busy <= (left != 4'h1);
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_pos <= 32'h0000_0100;
		end else if (o_busy) begin
			o_pos <= o_pos + 32'h1;
		end
	end

	// Nonvolatile write takes a few cycles
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			nv_left <= 3'h0;
		end else if (i_nv_write) begin
			nv_left <= 3'h4;
		end else if (nv_left != 3'h0) begin
			nv_left <= nv_left - 3'h1;
		end
	end
	assign o_nv_done = (nv_left == 3'h1);
endmodule : motion_far_end
`default_nettype wire

// ### tb/motion_input_command_dispatch_test.sv
// Self-checking bench for the motion input dispatcher
`timescale 1ns/100ps
`default_nettype none
module motion_input_command_dispatch_test import motion_pkg::*;;
	logic i_clk, i_nrst, cyc, we, ack, busy, done, decel, nvd, nvw, pload;
	logic hdone, pip, err, mval, pip_seen, eact, alm, alm_seen;
	logic [11:0] adr;
	logic [31:0] wdat, rdat, rd, pos, pval, pv, eoff;
	logic [7:0] dsel;
	logic [39:0] mdat;
	din_t din;
	motion_cmd_t cmd, got;
	int errors, checks_done;

	motion_input_command_dispatch u_dut (.i_clk(i_clk), .i_nrst(i_nrst),
		.i_wb_cyc(cyc), .i_wb_stb(cyc), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hf),
		.i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack), .i_din(din), .i_data_sel(dsel),
		.i_motion_busy(busy), .i_motion_done(done), .i_decelerating(decel),
		.i_nv_done(nvd), .i_home_invalidate(1'b0), .i_fb_pos(pos), .i_cmd_pos(pos),
		.i_fb_cnt32(32'h0000_0011), .i_cmd_cnt32(32'h0000_0022), .i_alarm_code(8'h33),
		.o_cmd(cmd), .o_homing_done(hdone), .o_preset_in_progress(pip), .o_pos_load(pload),
		.o_nv_write(nvw), .o_pos_load_value(pval), .o_elec_active(eact), .o_elec_offset(eoff),
		.o_limit_alarm(alm), .o_fast_home_err(err), .o_mon_data(mdat), .o_mon_valid(mval));
	motion_far_end u_far (.i_clk(i_clk), .i_nrst(i_nrst), .i_cmd(cmd), .i_nv_write(nvw),
		.o_busy(busy), .o_done(done), .o_decel(decel), .o_nv_done(nvd), .o_pos(pos));

	task check(input string what, input logic [39:0] seen, input logic [39:0] exp);
		checks_done++;
		if (seen !== exp) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task wb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge i_clk);
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do @(posedge i_clk); while (ack !== 1'b1);
		rd = rdat;
		cyc <= 1'b0;
		@(posedge i_clk);
	endtask : wb

	// Pulses one input, records command, load value and preset flag seen meanwhile
	task fire(input int b);
		got = '0;
		pip_seen = 1'b0;
		alm_seen = 1'b0;
		@(posedge i_clk);
		din[b] <= 1'b1;
		repeat (10) begin
			@(posedge i_clk);
			#1;
			if (cmd.valid) got = cmd;
			if (pload) pv = pval;
			if (pip) pip_seen = 1'b1;
			if (alm) alm_seen = 1'b1;
		end
		@(posedge i_clk);
		din[b] <= 1'b0;
		repeat (20) @(posedge i_clk);
	endtask : fire

	task t_regs;
		wb(1'b0, REG_CONFIG, 32'h0);
		check("config", 40'(rd), 40'h0008_0112);
		wb(1'b0, 12'h100, 32'h0);
		check("unmapped", 40'(rd), 40'h0);
		$display("test regs done");
	endtask : t_regs

	task t_run;
		wb(1'b1, 12'h414, 32'h0000_1234);
		fire(10);
		check("run kind", 40'(got.kind), 40'(CMD_RUN));
		check("run dir", 40'(got.rev), 40'h0);
		check("run speed", 40'(got.speed), 40'h1234);
		$display("test run done");
	endtask : t_run

	task t_jogs;
		for (int i = 0; i < 8; i++) begin
			fire(18 - i);
			check("jog kind", 40'(got.kind), 40'(4'(CMD_JOG) + 4'(i / 2)));
			check("jog dir", 40'(got.rev), 40'(i % 2));
		end
		$display("test jogs done");
	endtask : t_jogs

	task t_fast_home;
		fire(20);
		check("no motion", 40'(got.valid), 40'h0);
		check("home error", 40'(err), 40'h1);
		$display("test fast home done");
	endtask : t_fast_home

	task t_preset;
		wb(1'b1, REG_PRESET, 32'h0000_0abc);
		fire(4);
		check("preset value", 40'(pv), 40'h0abc);
		check("in progress", 40'(pip_seen), 40'h1);
		check("homing done", 40'({hdone, pip}), 40'h2);
		din.monitor_select_a <= 1'b1;
		repeat (5) @(posedge i_clk);
		check("monitor valid", 40'(mval), 40'h1);
		check("monitor", mdat, {8'h00, pos});
		$display("test preset done");
	endtask : t_preset

	task t_motion;
		din.run_rev <= 1'b1;
		fire(10);
		check("both run", 40'(got.kind), 40'(CMD_STOP_DECEL));
		{din.run_rev, din.jog_fwd} <= 2'b01;
		repeat (3) @(posedge i_clk);
		fire(8);
		check("limit stop", 40'(got.kind), 40'(CMD_STOP_IMM));
		check("limit alarm", 40'(alm_seen), 40'h1);
		din.jog_fwd <= 1'b0;
		repeat (20) @(posedge i_clk);
		$display("test motion done");
	endtask : t_motion

	task t_elec;
		din.electrical_origin_hold <= 1'b1;
		repeat (5) @(posedge i_clk);
		check("elec active", 40'(eact), 40'h1);
		check("elec offset", 40'(eoff), 40'(pos));
		check("monitor rel", mdat, 40'h0);
		fire(20);
		check("inhibit", 40'(got.valid), 40'h0);
		din.electrical_origin_hold <= 1'b0;
		fire(20);
		check("fast home", 40'(got.kind), 40'(CMD_FAST_HOME));
		$display("test elec done");
	endtask : t_elec

	task t_home;
		fire(19);
		check("home seek", 40'(got.kind), 40'(CMD_HOME_SEEK));
		check("home start", 40'(hdone), 40'h0);
		fire(7);
		check("home turn", 40'(got.rev), 40'h1);
		fire(6);
		check("home stop", 40'(got.kind), 40'(CMD_STOP_IMM));
		check("home done", 40'(hdone), 40'h1);
		$display("test home done");
	endtask : t_home

	task give_verdict;
		$display("checks %0d mismatches %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : give_verdict

	initial begin
		i_clk = 1'b0;
		forever #5 i_clk = ~i_clk;
	end

	initial begin
		repeat (5000) @(posedge i_clk);
		errors++;
		give_verdict();
	end

	initial begin
		{i_nrst, cyc, we, adr, wdat, din} = '0;
		dsel = 8'h05;
		repeat (10) @(posedge i_clk);
		i_nrst <= 1'b1;
		t_regs();
		t_run();
		t_jogs();
		t_motion();
		t_fast_home();
		t_preset();
		t_elec();
		t_home();
		give_verdict();
	end
endmodule : motion_input_command_dispatch_test
`default_nettype wire
